// File: logic/adc_store_pkg.sv
// Constants, field layouts and carrier types for the result store
//Contract
//- Finished results land in four read-only pairs
//- Fixed continuous fills pairs zero to three
//- Other modes: input modulo four picks pair
//- Low register bit 0 flags fresh result
//- Reading either half clears that pair's flag
//- Reading any result clears conversion done flag
//- Completion seen by polling or by interrupt
//- Repeat/scan bits select the four modes
//- Process end sets done flag, pulses request
`default_nettype none
package adc_store_pkg;
	localparam int RES_W   = 10;
	localparam int CH_W    = 3;
	localparam int PAIRS   = 4;
	localparam int ADDR_W  = 8;
	localparam int DATA_W  = 32;

	// Register byte offsets
	localparam logic [7:0] OFF_MODE0  = 8'h00;
	localparam logic [7:0] OFF_STATUS = 8'h04;
	localparam logic [2:0] RES_BLOCK  = 3'h1; // paddr[7:5], 0x20..0x3C
	localparam int         PAIR_LSB   = 3;    // paddr[4:3] picks the pair
	localparam int         HIGH_BIT   = 2;    // paddr[2] picks high half

	// Mode register fields
	localparam int         SCAN_POS   = 0;
	localparam int         REPEAT_POS = 1;
	localparam int         EOC_POS    = 2;
	localparam logic [1:0] MODE_RESET = 2'h0;

	// Result register fields
	localparam int VALID_POS   = 0;
	localparam int LOW_DATA_LSB = 6;  // low two result bits at [7:6]
	localparam int LOW_BITS     = 2;

	// Repeat and scan bits together
	typedef enum logic [1:0] {
		FIXED_SINGLE = 2'h0,
		SCAN_SINGLE  = 2'h1,
		FIXED_CONT   = 2'h2,
		SCAN_CONT    = 2'h3
	} conv_mode_e;

	// One finished conversion from the core
	typedef struct packed {
		logic [CH_W-1:0]  channel;
		logic [RES_W-1:0] value;
	} conv_result_s;
endpackage
`default_nettype wire

// File: logic/result_pair.sv
// One result register pair with its fresh-result flag
`timescale 1ns/1ns
`default_nettype none
module result_pair
	import adc_store_pkg::*;
#(
	parameter int W = RES_W
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         load,
	input  wire logic [W-1:0] value_in,
	input  wire logic         read_clear,
	output logic      [W-1:0] value,
	output logic              valid
);
	logic [W-1:0] next_value;
	logic         next_valid;

	// Load sets the flag; a read in the same cycle must not lose it
	always_comb begin
		next_value = load ? value_in : value;
		next_valid = load | (valid & ~read_clear);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			value <= '0;
			valid <= 1'b0;
		end else begin
			value <= next_value;
			valid <= next_valid;
		end
	end
endmodule
`default_nettype wire

// File: logic/adc_result_store.sv
// APB result store of the eight-input converter
`timescale 1ns/1ns
`default_nettype none
module adc_result_store
	import adc_store_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [ADDR_W-1:0] paddr,
	input  wire logic [DATA_W-1:0] pwdata,
	output logic      [DATA_W-1:0] prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic              conv_valid,
	input  wire conv_result_s      conv_result,
	input  wire logic              conv_end,
	output logic                   repeat_mode,
	output logic                   scan_mode,
	output logic                   conversion_done_flag,
	output logic                   conversion_done_irq
);
	conv_mode_e        mode;
	logic [1:0]        fill_ptr;
	logic              access;
	logic              is_res;
	logic [1:0]        pair_sel;
	logic [PAIRS-1:0]  load_vec;
	logic [PAIRS-1:0]  clear_vec;
	logic [PAIRS-1:0]  valid_vec;
	logic [1:0]        dest;
	logic [RES_W-1:0]  pair_value [PAIRS];
	logic [DATA_W-1:0] rd_word;
	logic              mapped;
	logic              next_pready;
	logic              next_pslverr;
	logic [DATA_W-1:0] next_prdata;
	logic [1:0]        next_mode_bits;
	logic [1:0]        next_fill_ptr;
	logic              next_done_flag;
	logic              next_irq;
	logic              mode_wr;

	assign mode        = conv_mode_e'({repeat_mode, scan_mode});
	assign access      = psel & penable & pready;
	assign is_res      = (paddr[7:5] == RES_BLOCK);
	assign pair_sel    = paddr[PAIR_LSB+1:PAIR_LSB];
	assign mode_wr     = access & pwrite & (paddr == OFF_MODE0);

	// Destination pair: rotating slot or input number modulo four
	assign dest = (mode == FIXED_CONT) ? fill_ptr
	                                   : conv_result.channel[1:0];

	// Load and read-clear strobes for each pair
	always_comb begin
		for (int k = 0; k < PAIRS; k++) begin
			load_vec[k]  = conv_valid & (dest == 2'(k));
			clear_vec[k] = access & ~pwrite & is_res & (pair_sel == 2'(k));
		end
	end

	// Result storage; software has no write path here
	for (genvar g = 0; g < PAIRS; g++) begin : g_pair
		result_pair #(.W(RES_W)) u_pair (
			.pclk      (pclk),
			.presetn   (presetn),
			.load      (load_vec[g]),
			.value_in  (conv_result.value),
			.read_clear(clear_vec[g]),
			.value     (pair_value[g]),
			.valid     (valid_vec[g])
		);
	end

	// Read mux; result words are read only
	always_comb begin
		rd_word = '0;
		mapped  = 1'b1;
		if (is_res) begin
			if (paddr[HIGH_BIT])
				rd_word[7:0] = pair_value[pair_sel][RES_W-1:LOW_BITS];
			else begin
				rd_word[LOW_DATA_LSB+LOW_BITS-1:LOW_DATA_LSB] =
					pair_value[pair_sel][LOW_BITS-1:0];
				rd_word[VALID_POS] = valid_vec[pair_sel];
			end
			mapped = (paddr[1:0] == 2'h0);
		end else if (paddr == OFF_MODE0) begin
			rd_word[SCAN_POS]   = scan_mode;
			rd_word[REPEAT_POS] = repeat_mode;
			rd_word[EOC_POS]    = conversion_done_flag;
		end else if (paddr == OFF_STATUS) begin
			rd_word[PAIRS-1:0] = valid_vec;
		end else begin
			mapped = 1'b0;
		end
	end

	// One wait state so read data leaves straight from a flop
	always_comb begin
		next_pready  = psel & penable & ~pready;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (psel & penable & ~pready) begin
			next_prdata  = pwrite ? '0 : rd_word;
			next_pslverr = ~mapped;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= next_pready;
			pslverr <= next_pslverr;
			prdata  <= next_prdata;
		end
	end

	// Mode bits, fill pointer, done flag and request pulse
	always_comb begin
		next_mode_bits = mode_wr ? {pwdata[REPEAT_POS], pwdata[SCAN_POS]}
		                         : {repeat_mode, scan_mode};
		next_fill_ptr  = fill_ptr;
		if (mode_wr)
			next_fill_ptr = 2'h0; // Restart the ring on any mode change
		else if (conv_valid && mode == FIXED_CONT)
			next_fill_ptr = fill_ptr + 2'h1;
		// Set wins over a read in the same cycle
		next_done_flag = conv_end | (conversion_done_flag &
			~(access & ~pwrite & is_res));
		next_irq = conv_end;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			repeat_mode          <= MODE_RESET[REPEAT_POS];
			scan_mode            <= MODE_RESET[SCAN_POS];
			fill_ptr             <= 2'h0;
			conversion_done_flag <= 1'b0;
			conversion_done_irq  <= 1'b0;
		end else begin
			{repeat_mode, scan_mode} <= next_mode_bits;
			fill_ptr                 <= next_fill_ptr;
			conversion_done_flag     <= next_done_flag;
			conversion_done_irq      <= next_irq;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_load_sets_valid: assert property (
		conv_valid |=> valid_vec[$past(dest)])
		else $error("pair flag not set after load");
	a_read_clears_valid: assert property (
		(access && !pwrite && is_res && !conv_valid)
		|=> !valid_vec[$past(pair_sel)])
		else $error("pair flag survived a read");
	a_fixed_cont_ring: assert property (
		(conv_valid && mode == FIXED_CONT && !mode_wr)
		|=> fill_ptr == $past(fill_ptr) + 2'h1)
		else $error("fill pointer did not advance");
	a_ring_wraps: assert property (
		(conv_valid && mode == FIXED_CONT && fill_ptr == 2'h3 && !mode_wr)
		|=> fill_ptr == 2'h0)
		else $error("fill pointer did not wrap");
	a_other_mode_map: assert property (
		(conv_valid && mode != FIXED_CONT)
		|=> pair_value[$past(conv_result.channel[1:0])]
			== $past(conv_result.value))
		else $error("result in wrong pair");
	a_read_clears_done: assert property (
		(access && !pwrite && is_res && !conv_end)
		|=> !conversion_done_flag)
		else $error("done flag survived result read");
	a_end_sets_done: assert property (
		conv_end |=> conversion_done_flag && conversion_done_irq
		##1 !conversion_done_irq || $past(conv_end))
		else $error("process end not flagged");
	a_mode_decode: assert property (
		mode_wr |=> {repeat_mode, scan_mode}
			== {$past(pwdata[REPEAT_POS]), $past(pwdata[SCAN_POS])})
		else $error("mode bits not stored");
	a_result_read_only: assert property (
		(access && pwrite && is_res && !conv_valid)
		|=> $stable(valid_vec))
		else $error("write touched a result pair");
	a_ready_one_wait: assert property (
		(psel && penable && !pready) |=> pready ##1 !pready)
		else $error("ready timing broken");

	// Error answer only for holes in the map, never for a mapped word
	a_unmapped_error: assert property (
		(psel && penable && !pready && !mapped) |=> pready && pslverr)
		else $error("unmapped access not refused");
	a_mapped_no_error: assert property (
		(psel && penable && !pready && mapped) |=> pready && !pslverr)
		else $error("mapped access refused");
	// Request stays a pulse; a stretched one would double-count ends
	a_irq_single_pulse: assert property (
		(conversion_done_irq && !conv_end) |=> !conversion_done_irq)
		else $error("request pulse stretched");
	// Ring only moves on a load or a mode write
	a_ring_idle: assert property (
		(!conv_valid && !mode_wr) |=> $stable(fill_ptr))
		else $error("fill pointer moved without a load");

	c_fixed_cont_wrap: cover property (
		conv_valid && mode == FIXED_CONT && fill_ptr == 2'h3);
	c_scan_upper_input: cover property (
		conv_valid && mode == SCAN_CONT && conv_result.channel[2]);
	c_read_with_load: cover property (
		conv_valid && access && !pwrite && is_res);
	c_poll_done: cover property (
		access && !pwrite && paddr == OFF_MODE0 && conversion_done_flag);
	// Plain single conversions still land by input number
	c_fixed_single_load: cover property (
		conv_valid && mode == FIXED_SINGLE);
endmodule
`default_nettype wire

// File: dv/testbench.sv
// Self-checking bench for the APB result store
`timescale 1ns/1ns
`default_nettype none
module testbench;
	import adc_store_pkg::*;
	logic              pclk, presetn, psel, penable, pwrite;
	logic [ADDR_W-1:0] paddr;
	logic [DATA_W-1:0] pwdata, prdata, rd;
	logic              pready, pslverr, er, conv_valid, conv_end;
	conv_result_s      conv_result;
	logic              repeat_mode, scan_mode;
	logic              conversion_done_flag, conversion_done_irq;
	logic [RES_W-1:0]  v [8];
	int                n_errors, checks_done;
	// Bench clocks per converter clock, slowest divider
	localparam int     FADC_DIV = 8;

	adc_result_store dut (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv_valid(conv_valid),
		.conv_result(conv_result), .conv_end(conv_end),
		.repeat_mode(repeat_mode), .scan_mode(scan_mode),
		.conversion_done_flag(conversion_done_flag),
		.conversion_done_irq(conversion_done_irq)
	);

	// 100 MHz clock
	always #5 pclk = ~pclk;

	// Verdict and end of run
	task summarize;
		if (n_errors == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Compare one value
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_errors++;
			$display("wrong value at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int i;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 20);
		if (i >= 20) begin
			n_errors++;
			summarize();
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// One finished conversion from the core, then a gap cycle
	task conv(input logic [2:0] ch, input logic [9:0] val);
		@(posedge pclk);
		conv_valid <= 1'b1;
		conv_result <= {ch, val};
		@(posedge pclk);
		conv_valid <= 1'b0;
	endtask

	// Expected low half: two result bits and the fresh flag
	function logic [31:0] lo(input logic [9:0] val, input logic f);
		return {24'h0, val[1:0], 5'h0, f};
	endfunction

	initial begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		conv_valid = 0;
		conv_end = 0;
		conv_result = '0;
		n_errors = 0;
		checks_done = 0;
		for (int i = 0; i < 8; i++)
			v[i] = 10'(10'h3A5 ^ (i * 77));
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 8'h00, 0); chk(rd, 0);
		apb(0, 8'h04, 0); chk(rd, 0);
		// Every mode code reaches the core controls
		for (int m = 0; m < 4; m++) begin
			apb(1, 8'h00, 32'(m));
			apb(0, 8'h00, 0); chk(rd, 32'(m));
			chk({repeat_mode, scan_mode}, 32'(m));
		end
		// Scan single: upper inputs overwrite their shared pair
		apb(1, 8'h00, 32'h1);
		for (int i = 0; i < 8; i++)
			conv(3'(i), v[i]);
		repeat (2 * FADC_DIV) @(posedge pclk);
		apb(0, 8'h04, 0); chk(rd, 32'hF);
		for (int k = 0; k < 4; k++) begin
			apb(0, {3'h1, 2'(k), 3'h4}, 0); chk(rd, {24'h0, v[k+4][9:2]});
			apb(0, {3'h1, 2'(k), 3'h0}, 0); chk(rd, lo(v[k+4], 0));
		end
		apb(0, 8'h04, 0); chk(rd, 0);
		// Fixed continuous: channel ignored, fifth result wraps to pair zero
		apb(1, 8'h00, 32'h2);
		for (int i = 0; i < 5; i++)
			conv(3'h5, v[i]);
		repeat (FADC_DIV) @(posedge pclk);
		apb(0, 8'h04, 0); chk(rd, 32'hF);
		for (int k = 0; k < 4; k++) begin
			apb(0, {3'h1, 2'(k), 3'h0}, 0); chk(rd, lo(v[k == 0 ? 4 : k], 1));
		end
		apb(0, 8'h04, 0); chk(rd, 0);
		// Process end raises flag and a one-cycle request
		@(posedge pclk);
		conv_end <= 1'b1;
		@(posedge pclk);
		conv_end <= 1'b0;
		#1 chk(conversion_done_irq, 1);
		chk(conversion_done_flag, 1);
		@(posedge pclk);
		#1 chk(conversion_done_irq, 0);
		apb(0, 8'h00, 0); chk(rd, 32'h6);
		// Result writes are dropped without error; a result read clears done
		apb(1, 8'h28, 32'hFFFFFFFF); chk(er, 0);
		apb(0, 8'h28, 0); chk(rd, lo(v[1], 0));
		#1 chk(conversion_done_flag, 0);
		// Unmapped offset answers with an error and zero data
		apb(0, 8'h10, 0);
		chk(er, 1);
		chk(rd, 0);
		// Fixed single and scan continuous also map by input number
		apb(1, 8'h00, 32'h0);
		conv(3'h6, v[6]);
		apb(1, 8'h00, 32'h3);
		conv(3'h7, v[7]);
		repeat (2 * FADC_DIV) @(posedge pclk);
		apb(0, 8'h34, 0);
		chk(rd, {24'h0, v[6][9:2]});
		apb(0, 8'h3C, 0);
		chk(rd, {24'h0, v[7][9:2]});
		summarize();
	end
endmodule
`default_nettype wire
